//--- rtl/dsp_pkg.sv
// Purpose: Shared constants for the drive select, protect and sector block
// Assumes: 20 MHz pclk, 32-bit APB register bus
// Notes: Register offsets are byte addresses
package dsp_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h10;

  // Protect scope encodings (CTRL bits 1:0)
  localparam logic [1:0] SCOPE_REMOVABLE = 2'h0;
  localparam logic [1:0] SCOPE_FIXED = 2'h1;
  localparam logic [1:0] SCOPE_ALL = 2'h2;
  localparam logic [1:0] CTRL_RESET = SCOPE_ALL;
  localparam int CTRL_SCOPE_LSB = 0;
  localparam int CTRL_SCOPE_W = 2;

  // Interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_INDEX = 0;
  localparam int IRQ_SECTOR = 1;
  localparam int IRQ_PROTECT = 2;
  localparam int IRQ_READY = 3;

  // STATUS field positions
  localparam int ST_PROTECT = 0;
  localparam int ST_SPEED_OK = 1;
  localparam int ST_HEAD_LOAD = 2;
  localparam int ST_SPINDLE = 3;
  localparam int ST_SELECTED = 4;
  localparam int ST_UNIT_LSB = 8;
  localparam int ST_SECTOR_LSB = 16;

  // Disk indices on the transducer inputs
  localparam int DISK_FIXED = 0;
  localparam int DISK_REMOVABLE = 1;
  localparam int NUM_DISKS = 2;
  localparam int NUM_UNITS = 4;
  localparam int SECTOR_W = 5;
  localparam logic [SECTOR_W-1:0] SECTOR_ZERO = 5'h00;
  localparam logic [SECTOR_W-1:0] SECTOR_MAX = 5'h17;

  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int INDEX_MIN_NS = 1000;
  localparam int INDEX_MIN_CYC = (INDEX_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int DATA_WIN_NS = 300;
  localparam int DATA_WIN_CYC = DATA_WIN_NS / CLK_NS;

  typedef enum logic [1:0] {ST_RETRACT, ST_SPIN, ST_LOADED} dsp_start_type;
endpackage

//--- rtl/dsp_sync2.sv
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Pins are independent levels
// Notes: First stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module dsp_sync2 #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

//--- rtl/dsp_drive_ctl.sv
// Purpose: Read gating, unit select, start-up, write protect and sector counter
// Assumes: All pin inputs asynchronous to pclk; APB register access
// Notes: Operation
// Operation
// - Read path outputs stay quiet while read gate is low.
// - Read pulses split into separate clock and data pulse lines.
// - Unit number from jumper; only that select line is honoured.
// - All interface outputs inactive until selected, except attention.
// - Attention goes out on the line of the configured unit.
// - One index pulse per revolution per disk from the hub slot.
// - Heads load only once lower disk index rate shows speed.
// - Index marks of the selected disk go to the controller.
// - Heads retracted after power-up and while in load position.
// - Entering run spins spindle and runs a brush pass.
// - Start-up sets protect: inhibit write, lamp on, status true.
// - Protect switch press clears protect, lamp and status.
// - Controller protect pulse sets protect again at any time.
// - Protect scope selectable: removable, fixed or all surfaces.
// - Sector marks told apart from index marks on one signal.
// - With option, selected disk sector marks go out and counted.
// - Sector counter gives a five-bit sector number.
// - Counter handles 8 to 24 sectors; fixed disk has 24.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module dsp_drive_ctl
  import dsp_pkg::*;
#(
  parameter int SPEED_MAX_CYC = 555_555,
  parameter int BRUSH_CYC = 200_000,
  parameter bit SECTOR_OPT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic read_gate,
  input wire logic read_pulse,
  input wire logic [NUM_UNITS-1:0] unit_sel,
  input wire logic [1:0] unit_jumper,
  input wire logic disk_sel,
  input wire logic [NUM_DISKS-1:0] xdcr,
  input wire logic load_run,
  input wire logic protect_switch,
  input wire logic protect_pulse,
  output logic read_clock,
  output logic read_data,
  output logic [NUM_UNITS-1:0] attention,
  output logic index_out,
  output logic sector_out,
  output logic [SECTOR_W-1:0] sector_count,
  output logic protect_status,
  output logic protect_lamp,
  output logic write_inhibit_removable,
  output logic write_inhibit_fixed,
  output logic spindle_on,
  output logic brush_run,
  output logic head_load,
  output logic heads_retract
);
  localparam int SW = 14;
  localparam int WID_W = $clog2(INDEX_MIN_CYC + 1);
  localparam int WIN_W = $clog2(DATA_WIN_CYC + 1);
  localparam int PER_W = $clog2(SPEED_MAX_CYC + 2);
  localparam int BR_W = $clog2(BRUSH_CYC + 1);
  localparam logic [WID_W-1:0] WID_LIM = WID_W'(INDEX_MIN_CYC);
  localparam logic [WIN_W-1:0] WIN_LIM = WIN_W'(DATA_WIN_CYC);
  localparam logic [PER_W-1:0] PER_LIM = PER_W'(SPEED_MAX_CYC);
  localparam logic [BR_W-1:0] BR_LIM = BR_W'(BRUSH_CYC);

  logic [SW-1:0] pins_s;
  logic rg_s, rp_s, dsel_s, run_s, psw_s, ppl_s;
  logic [NUM_UNITS-1:0] usel_s;
  logic [1:0] jmp_s;
  logic [NUM_DISKS-1:0] xd_s;

  dsp_sync2 #(.W(SW)) i_dsp_sync2 (
    .pclk(pclk),
    .presetn(presetn),
    .d({read_gate, read_pulse, unit_sel, unit_jumper, disk_sel, xdcr, load_run,
        protect_switch, protect_pulse}),
    .q(pins_s)
  );
  assign {rg_s, rp_s, usel_s, jmp_s, dsel_s, xd_s, run_s, psw_s, ppl_s} = pins_s;

  // Previous values for edge detection
  logic rp_d, psw_d, ppl_d;
  logic [NUM_DISKS-1:0] xd_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp_d <= 1'b0;
      psw_d <= 1'b0;
      ppl_d <= 1'b0;
      xd_d <= '0;
    end else begin
      rp_d <= rp_s;
      psw_d <= psw_s;
      ppl_d <= ppl_s;
      xd_d <= xd_s;
    end
  end
  wire rp_rise = rp_s & ~rp_d;
  wire psw_rise = psw_s & ~psw_d;
  wire ppl_rise = ppl_s & ~ppl_d;

  // Unit jumper is static; register it continuously
  logic [1:0] unit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) unit <= 2'h0;
    else unit <= jmp_s;
  end
  wire selected = usel_s[unit];

  // Index and sector discrimination by pulse width
  logic [WID_W-1:0] wid [NUM_DISKS];
  logic [NUM_DISKS-1:0] idx_p, sec_p;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_DISKS; i++) wid[i] <= '0;
      idx_p <= '0;
      sec_p <= '0;
    end else begin
      for (int i = 0; i < NUM_DISKS; i++) begin
        if (xd_s[i] && wid[i] != WID_LIM) wid[i] <= wid[i] + 1'b1;
        else if (!xd_s[i]) wid[i] <= '0;
        idx_p[i] <= ~xd_s[i] & xd_d[i] & (wid[i] == WID_LIM);
        sec_p[i] <= ~xd_s[i] & xd_d[i] & (wid[i] != WID_LIM);
      end
    end
  end

  // Spindle speed from lower disk index period; no valid period while stopped
  logic [PER_W-1:0] period;
  logic speed_ok;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period <= '0;
      speed_ok <= 1'b0;
    end else if (!run_s || idx_p[DISK_FIXED]) begin
      period <= run_s ? '0 : PER_LIM + 1'b1;
      speed_ok <= run_s && (period <= PER_LIM);
    end else if (period > PER_LIM) begin
      speed_ok <= 1'b0;
    end else begin
      period <= period + 1'b1;
    end
  end

  // Start-up sequence
  dsp_start_type state;
  logic [BR_W-1:0] brush_cnt;
  wire start_entry = (state == ST_RETRACT) && run_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RETRACT;
      brush_cnt <= '0;
    end else begin
      case (state)
        ST_RETRACT: begin
          brush_cnt <= '0;
          if (run_s) state <= ST_SPIN;
        end
        ST_SPIN: begin
          if (!run_s) state <= ST_RETRACT;
          else if (brush_cnt != BR_LIM) brush_cnt <= brush_cnt + 1'b1;
          else if (speed_ok) state <= ST_LOADED;
        end
        ST_LOADED: begin
          if (!run_s || !speed_ok) state <= ST_RETRACT;
        end
        default: state <= ST_RETRACT;
      endcase
    end
  end
  assign spindle_on = (state != ST_RETRACT);
  assign brush_run = (state == ST_SPIN) && (brush_cnt != BR_LIM);
  assign head_load = (state == ST_LOADED);
  assign heads_retract = ~head_load;

  // Write protect flip-flop; set wins over the switch clear
  logic protect;
  logic [CTRL_SCOPE_W-1:0] scope;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) protect <= 1'b1;
    else if (start_entry || ppl_rise) protect <= 1'b1;
    else if (psw_rise) protect <= 1'b0;
  end
  assign protect_lamp = protect;
  assign write_inhibit_removable = protect && (scope != SCOPE_FIXED);
  assign write_inhibit_fixed = protect && (scope != SCOPE_REMOVABLE);

  // Sector counter on the selected disk
  logic [SECTOR_W-1:0] sec_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sec_cnt <= SECTOR_ZERO;
    else if (!SECTOR_OPT || idx_p[dsel_s]) sec_cnt <= SECTOR_ZERO;
    else if (sec_p[dsel_s] && sec_cnt != SECTOR_MAX) sec_cnt <= sec_cnt + 1'b1;
  end

  // Read clock/data separation using a data window after each clock
  logic [WIN_W-1:0] win;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) win <= '0;
    else if (!rg_s) win <= '0;
    else if (rp_rise && win == '0) win <= WIN_LIM;
    else if (win != '0) win <= win - 1'b1;
  end

  // Interface outputs, gated by unit selection except attention
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_clock <= 1'b0;
      read_data <= 1'b0;
      index_out <= 1'b0;
      sector_out <= 1'b0;
      sector_count <= SECTOR_ZERO;
      protect_status <= 1'b0;
      attention <= '0;
    end else begin
      read_clock <= selected && rg_s && rp_rise && (win == '0);
      read_data <= selected && rg_s && rp_rise && (win != '0);
      index_out <= selected && idx_p[dsel_s];
      sector_out <= selected && SECTOR_OPT && sec_p[dsel_s];
      sector_count <= selected ? sec_cnt : SECTOR_ZERO;
      protect_status <= selected && protect;
      attention <= '0;
      attention[unit] <= head_load;
    end
  end

  // APB slave, zero wait states
  wire setup = psel && !penable;
  wire access_wr = psel && penable && pwrite;
  wire mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_IRQ_STAT)
    || (paddr == ADDR_IRQ_CLR) || (paddr == ADDR_IRQ_EN);
  logic [IRQ_W-1:0] irq_stat, irq_en, irq_ev;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) scope <= CTRL_RESET;
    else if (access_wr && paddr == ADDR_CTRL)
      scope <= pwdata[CTRL_SCOPE_LSB +: CTRL_SCOPE_W];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_en <= '0;
    else if (access_wr && paddr == ADDR_IRQ_EN) irq_en <= pwdata[IRQ_W-1:0];
  end

  logic head_load_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) head_load_d <= 1'b0;
    else head_load_d <= head_load;
  end

  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_INDEX] = idx_p[dsel_s];
    irq_ev[IRQ_SECTOR] = sec_p[dsel_s];
    irq_ev[IRQ_PROTECT] = start_entry || ppl_rise;
    irq_ev[IRQ_READY] = head_load && !head_load_d;
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_stat <= '0;
    else if (access_wr && paddr == ADDR_IRQ_CLR)
      irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_ev;
    else irq_stat <= irq_stat | irq_ev;
  end
  assign irq = |(irq_stat & irq_en);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        ADDR_CTRL: prdata[CTRL_SCOPE_LSB +: CTRL_SCOPE_W] <= scope;
        ADDR_STATUS: begin
          prdata[ST_PROTECT] <= protect;
          prdata[ST_SPEED_OK] <= speed_ok;
          prdata[ST_HEAD_LOAD] <= head_load;
          prdata[ST_SPINDLE] <= spindle_on;
          prdata[ST_SELECTED] <= selected;
          prdata[ST_UNIT_LSB +: 2] <= unit;
          prdata[ST_SECTOR_LSB +: SECTOR_W] <= sec_cnt;
        end
        ADDR_IRQ_STAT: prdata[IRQ_W-1:0] <= irq_stat;
        ADDR_IRQ_EN: prdata[IRQ_W-1:0] <= irq_en;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  property p_read_gate_quiet;
    @(posedge pclk) disable iff (!presetn)
      !rg_s |=> !read_clock && !read_data;
  endproperty
  a_read_gate_quiet: assert property (p_read_gate_quiet)
    else $error("read output while read gate low");

  property p_clock_data_split;
    @(posedge pclk) disable iff (!presetn)
      read_clock |-> !read_data ##1 !read_data;
  endproperty
  a_clock_data_split: assert property (p_clock_data_split)
    else $error("data pulse too soon after clock pulse");

  property p_unselected_quiet;
    @(posedge pclk) disable iff (!presetn)
      !selected |=> !index_out && !sector_out && !protect_status && sector_count == SECTOR_ZERO;
  endproperty
  a_unselected_quiet: assert property (p_unselected_quiet)
    else $error("interface active while unselected");

  property p_attention_unit;
    @(posedge pclk) disable iff (!presetn)
      head_load && $stable(unit) |=> attention[unit] && $onehot(attention);
  endproperty
  a_attention_unit: assert property (p_attention_unit)
    else $error("attention not on configured unit line");

  property p_load_needs_speed;
    @(posedge pclk) disable iff (!presetn)
      $rose(head_load) |-> $past(speed_ok) && $past(brush_cnt) == BR_LIM;
  endproperty
  a_load_needs_speed: assert property (p_load_needs_speed)
    else $error("heads loaded before speed or brush done");

  property p_load_retracts;
    @(posedge pclk) disable iff (!presetn)
      !run_s |=> heads_retract && !head_load;
  endproperty
  a_load_retracts: assert property (p_load_retracts)
    else $error("heads not retracted in load position");

  property p_start_protect;
    @(posedge pclk) disable iff (!presetn)
      start_entry |=> protect && spindle_on && write_inhibit_removable | write_inhibit_fixed;
  endproperty
  a_start_protect: assert property (p_start_protect)
    else $error("start-up did not set protect");

  property p_switch_clears;
    @(posedge pclk) disable iff (!presetn)
      psw_rise && !ppl_rise && !start_entry |=> !protect && !protect_lamp;
  endproperty
  a_switch_clears: assert property (p_switch_clears)
    else $error("switch press did not clear protect");

  property p_pulse_sets;
    @(posedge pclk) disable iff (!presetn)
      ppl_rise |=> protect ##1 (protect_status || !$past(selected));
  endproperty
  a_pulse_sets: assert property (p_pulse_sets)
    else $error("protect pulse did not set protect");

  property p_index_clears_count;
    @(posedge pclk) disable iff (!presetn)
      idx_p[dsel_s] |=> sec_cnt == SECTOR_ZERO;
  endproperty
  a_index_clears_count: assert property (p_index_clears_count)
    else $error("sector count not cleared by index");
endmodule
`default_nettype wire

//--- bench/dsp_ctl_model.sv
// Purpose: Controller side: select lines, disk select, read gate, protect pulse
// Assumes: Lines change right after a rising pclk edge
// Notes: Bench calls the tasks hierarchically
`timescale 1ns/1ns
`default_nettype none
module dsp_ctl_model (
  input wire logic pclk,
  output logic read_gate,
  output logic [3:0] unit_sel,
  output logic disk_sel,
  output logic protect_pulse
);
  initial begin
    read_gate = 1'b0;
    unit_sel = 4'h0;
    disk_sel = 1'b0;
    protect_pulse = 1'b0;
  end
  task automatic drive(input logic g, input logic [3:0] u, input logic d);
    @(posedge pclk);
    read_gate <= g;
    unit_sel <= u;
    disk_sel <= d;
  endtask
  task automatic pulse_protect();
    @(posedge pclk);
    protect_pulse <= 1'b1;
    repeat (3) @(posedge pclk);
    protect_pulse <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- bench/dsp_drive_ctl_tb.sv
// Purpose: Self-checking bench for drive select, protect and sector logic
// Assumes: Shortened speed and brush counts; unit strap set to unit 2
// Notes: Disk revolution of 150 cycles; index 25 cycles, sectors 5 cycles
`timescale 1ns/1ns
`default_nettype none
module dsp_drive_ctl_tb;
  import dsp_pkg::*;
  localparam int PER = 150;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic read_gate, read_pulse, disk_sel, load_run, protect_switch, protect_pulse;
  logic [3:0] unit_sel, attention;
  logic [1:0] xdcr, jmp;
  logic read_clock, read_data, index_out, sector_out, protect_status, protect_lamp;
  logic wir, wif, spindle_on, brush_run, head_load, heads_retract;
  logic [4:0] sector_count;
  int error_cnt, num_checks, ph, n_clk, n_dat, n_idx, n_sec, n;

  dsp_drive_ctl #(.SPEED_MAX_CYC(200), .BRUSH_CYC(20), .SECTOR_OPT(1'b1)) i_dsp_drive_ctl (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .read_gate, .read_pulse, .unit_sel, .unit_jumper(jmp), .disk_sel,
    .xdcr, .load_run, .protect_switch, .protect_pulse, .read_clock, .read_data,
    .attention, .index_out, .sector_out, .sector_count, .protect_status, .protect_lamp,
    .write_inhibit_removable(wir), .write_inhibit_fixed(wif), .spindle_on, .brush_run,
    .head_load, .heads_retract);
  dsp_ctl_model i_dsp_ctl_model (.pclk, .read_gate, .unit_sel, .disk_sel, .protect_pulse);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Spinning disks: index slot then sector slots, fixed 4, removable 2
  always @(posedge pclk) begin
    ph <= (ph == PER - 1) ? 0 : ph + 1;
    xdcr[0] <= load_run && (ph < 25 || (ph >= 40 && ph < 100 && (ph - 40) % 15 < 5));
    xdcr[1] <= load_run && (ph < 25 || (ph >= 40 && ph < 70 && (ph - 40) % 15 < 5));
    n_clk <= n_clk + int'(read_clock);
    n_dat <= n_dat + int'(read_data);
    n_idx <= (ph == 5) ? 0 : n_idx + int'(index_out);
    n_sec <= (ph == 5) ? 0 : n_sec + int'(sector_out);
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic rpulse(input int gap);
    @(posedge pclk);
    read_pulse <= 1'b1;
    @(posedge pclk);
    read_pulse <= 1'b0;
    repeat (gap) @(posedge pclk);
  endtask

  task automatic press();
    @(posedge pclk);
    protect_switch <= 1'b1;
    repeat (3) @(posedge pclk);
    protect_switch <= 1'b0;
    repeat (6) @(posedge pclk);
    #1;
  endtask

  task automatic wait_ph(input int p);
    do @(posedge pclk); while (ph != p);
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge pclk);
    error_cnt++;
    conclude();
  end

  initial begin
    {presetn, psel, penable, pwrite, read_pulse, load_run, protect_switch} = 7'h00;
    {paddr, pwdata, xdcr, jmp} = 44'h2;
    {ph, n_clk, n_dat, n_idx, n_sec, error_cnt, num_checks} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("retract", 1, heads_retract);
    chk("lamp", 1, protect_lamp);
    chk("status", 0, protect_status);
    chk("ready", 1, pready);
    rdchk("ctrl", ADDR_CTRL, 32'h2);
    rdchk("irq_en", ADDR_IRQ_EN, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 1, err);
    $display("test reset done");
    i_dsp_ctl_model.drive(1'b1, 4'h1, 1'b0);
    rpulse(10);
    chk("other unit", 0, protect_status);
    chk("clk other", 0, n_clk);
    i_dsp_ctl_model.drive(1'b0, 4'h4, 1'b0);
    rpulse(10);
    chk("own unit", 1, protect_status);
    chk("clk gated", 0, n_clk);
    i_dsp_ctl_model.drive(1'b1, 4'h4, 1'b0);
    rpulse(1);
    rpulse(10);
    rpulse(10);
    chk("clk n", 2, n_clk);
    chk("dat n", 1, n_dat);
    $display("test read done");
    press();
    chk("cleared", 0, {protect_status, protect_lamp, wir, wif});
    apb(1'b1, ADDR_IRQ_EN, 32'hF);
    @(posedge pclk);
    load_run <= 1'b1;
    repeat (8) @(posedge pclk);
    #1;
    chk("startup prot", 1, protect_status);
    chk("spin brush", 2'b11, {spindle_on, brush_run});
    chk("early load", 0, head_load);
    n = 0;
    while (head_load !== 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    #1;
    chk("speed wait", 1, n > 100);
    chk("loaded", 3'b100, {head_load, heads_retract, brush_run});
    chk("attention", 4'h4, attention);
    $display("test startup done");
    wait_ph(145);
    chk("index n", 1, n_idx);
    chk("sector n", 4, n_sec);
    chk("count", 4, sector_count);
    i_dsp_ctl_model.drive(1'b1, 4'h4, 1'b1);
    wait_ph(145);
    wait_ph(145);
    chk("rem sector n", 2, n_sec);
    chk("rem count", 2, sector_count);
    rdchk("status", ADDR_STATUS, 32'h0002_021F);
    $display("test sector done");
    rdchk("irq stat", ADDR_IRQ_STAT, 32'hF);
    chk("irq", 1, irq);
    apb(1'b1, ADDR_IRQ_EN, 32'h4);
    press();
    apb(1'b1, ADDR_IRQ_CLR, 32'h4);
    chk("irq clr", 0, {irq, protect_status});
    i_dsp_ctl_model.pulse_protect();
    repeat (6) @(posedge pclk);
    #1;
    chk("reprotect", 2'b11, {irq, protect_status});
    rdchk("clr reads", ADDR_IRQ_CLR, 32'h0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ADDR_CTRL, i);
      chk("scope", (i == 0) ? 2'b10 : (i == 1) ? 2'b01 : 2'b11, {wir, wif});
    end
    $display("test protect done");
    i_dsp_ctl_model.drive(1'b1, 4'h0, 1'b0);
    repeat (6) @(posedge pclk);
    #1;
    chk("desel", 0, {protect_status, sector_count});
    chk("attn kept", 4'h4, attention);
    @(posedge pclk);
    load_run <= 1'b0;
    repeat (6) @(posedge pclk);
    #1;
    chk("unload", 2'b01, {head_load, heads_retract});
    @(posedge pclk);
    jmp <= 2'h1;
    i_dsp_ctl_model.drive(1'b1, 4'h2, 1'b0);
    repeat (6) @(posedge pclk);
    #1;
    chk("jumper", 1, protect_status);
    $display("test unload done");
    conclude();
  end
endmodule
`default_nettype wire
